// ===== ldo_dis_pkg.sv
// Package: register map, field layout, reset values and carrier types
`default_nettype none
package ldo_dis_pkg;
    // ==========================================================
    // Register offsets
    localparam logic [7:0] ldo_second_control_off    = 8'h28;
    localparam logic [7:0] ldo_third_control_off     = 8'h29;
    localparam logic [7:0] buck_discharge_select_off = 8'h40;
    // ==========================================================
    // Field positions
    localparam int sleep_sel_lsb  = 4;
    localparam int reserved_lsb   = 1;
    localparam int permit_bit     = 0;
    localparam int buck_count     = 4;
    // ==========================================================
    // Values
    localparam logic [1:0] sleep_off_code  = 2'h0;
    localparam logic [1:0] sleep_on_code   = 2'h3;
    localparam logic [2:0] reserved_code   = 3'h6;
    localparam logic [1:0] dis_none        = 2'h0;
    localparam logic [1:0] dis_100_ohm     = 2'h1;
    localparam logic [1:0] dis_200_ohm     = 2'h2;
    localparam logic [1:0] dis_500_ohm     = 2'h3;
    // Reset values stand in for factory settings
    localparam logic [7:0] ldo_ctrl_reset  = 8'h0D;
    localparam logic [7:0] dis_sel_reset   = 8'h55;

    // ==========================================================
    // Carrier types
    typedef struct packed {
        logic [1:0] sleep_sel;
        logic [2:0] reserved;
        logic       on_permit;
    } ldo_ctrl_s;

    typedef struct packed {
        logic       load_100_ohm;
        logic       load_200_ohm;
        logic       load_500_ohm;
    } discharge_s;
endpackage : ldo_dis_pkg
`default_nettype wire

// ===== ldo_ctrl_discharge_regs.sv
// Control registers for two small regulators and the buck discharge selectors
// Overview of operation
// - Each regulator follows sleep pin a or b, chosen by factory strap
// - Sleep field 00 always selects the normal voltage code
// - Sleep field 11 selects sleep code while assigned pin is low
// - Permit bit 0 forces regulator off when clear, overriding control pins
// - Discharge code 00 none, 01 100 ohm, 10 200 ohm, 11 500 ohm
// - Discharge register holds four buck selectors, fourth in 7:6 to first in 1:0
// - A rail becoming enabled clears its discharge selector by itself
`timescale 1ns/1ps
`default_nettype none
module ldo_ctrl_discharge_regs (
    // Clock and reset
    input  wire logic                   mclk,
    input  wire logic                   reset,
    // Register port
    input  wire logic [7:0]             reg_addr,
    input  wire logic [7:0]             reg_wdata,
    input  wire logic                   reg_write,
    input  wire logic                   reg_read,
    output logic      [7:0]             reg_rdata,
    // Factory straps: 0 picks pin a, 1 picks pin b
    input  wire logic                   second_reg_pin_strap,
    input  wire logic                   third_reg_pin_strap,
    // Pins
    input  wire logic                   sleep_select_pin_a,
    input  wire logic                   sleep_select_pin_b,
    input  wire logic                   second_reg_enable_request,
    input  wire logic                   third_reg_enable_request,
    input  wire logic [3:0]             buck_rail_enabled,
    // Regulator control
    output logic                        second_reg_enable,
    output logic                        third_reg_enable,
    output logic                        second_reg_use_sleep_code,
    output logic                        third_reg_use_sleep_code,
    output ldo_dis_pkg::discharge_s     buck_discharge [4]
);
    // ==========================================================
    // Pin synchronisers
    logic [7:0] sync1_reg;
    logic [7:0] sync2_reg;
    logic [3:0] buck_en_prev_reg;
    logic       strap_second_reg;
    logic       strap_third_reg;
    logic       strap_taken_reg;
    logic [1:0] strap_meta_reg;
    logic [1:0] strap_sync_reg;
    wire logic  pin_a_s    = sync2_reg[0];
    wire logic  pin_b_s    = sync2_reg[1];
    wire logic  second_req = sync2_reg[2];
    wire logic  third_req  = sync2_reg[3];
    wire logic [3:0] buck_en_s = sync2_reg[7:4];

    always_ff @(posedge mclk) begin
        if (reset) begin
            sync1_reg <= 8'h00;
            sync2_reg <= 8'h00;
        end else begin
            sync1_reg <= {buck_rail_enabled, third_reg_enable_request,
                          second_reg_enable_request, sleep_select_pin_b, sleep_select_pin_a};
            sync2_reg <= sync1_reg;
        end
    end

    // Straps are pins too; left unreset so the stages fill while reset is held
    always_ff @(posedge mclk) begin
        strap_meta_reg <= {third_reg_pin_strap, second_reg_pin_strap};
        strap_sync_reg <= strap_meta_reg;
    end

    // Straps caught once after release, never under reset
    // Reset must span two edges, else the caught strap is stale
    always_ff @(posedge mclk) begin
        if (reset) begin
            strap_taken_reg  <= 1'b0;
            strap_second_reg <= 1'b0;
            strap_third_reg  <= 1'b0;
        end else if (!strap_taken_reg) begin
            strap_taken_reg  <= 1'b1;
            strap_second_reg <= strap_sync_reg[0];
            strap_third_reg  <= strap_sync_reg[1];
        end
    end

    // ==========================================================
    // Registers
    ldo_dis_pkg::ldo_ctrl_s second_ctrl_reg;
    ldo_dis_pkg::ldo_ctrl_s third_ctrl_reg;
    logic [7:0]             dis_sel_reg;
    logic [7:0]             dis_sel_next;
    logic [3:0]             buck_rise;

    always_ff @(posedge mclk) begin
        if (reset) begin
            second_ctrl_reg <= ldo_dis_pkg::ldo_ctrl_reset[5:0];
            third_ctrl_reg  <= ldo_dis_pkg::ldo_ctrl_reset[5:0];
        end else if (reg_write) begin
            // Reserved bits stored as written; software keeps them at 110
            if (reg_addr == ldo_dis_pkg::ldo_second_control_off)
                second_ctrl_reg <= reg_wdata[5:0];
            if (reg_addr == ldo_dis_pkg::ldo_third_control_off)
                third_ctrl_reg <= reg_wdata[5:0];
        end
    end

    assign buck_rise = buck_en_s & ~buck_en_prev_reg;

    // Hardware clear wins over a same-cycle software write
    always_comb begin
        dis_sel_next = dis_sel_reg;
        if (reg_write && reg_addr == ldo_dis_pkg::buck_discharge_select_off)
            dis_sel_next = reg_wdata;
        for (int i = 0; i < ldo_dis_pkg::buck_count; i++) begin
            if (buck_rise[i])
                dis_sel_next[2*i +: 2] = ldo_dis_pkg::dis_none;
        end
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            dis_sel_reg      <= ldo_dis_pkg::dis_sel_reset;
            buck_en_prev_reg <= 4'h0;
        end else begin
            dis_sel_reg      <= dis_sel_next;
            buck_en_prev_reg <= buck_en_s;
        end
    end

    // ==========================================================
    // Read port
    always_ff @(posedge mclk) begin
        if (reset) begin
            reg_rdata <= 8'h00;
        end else if (reg_read) begin
            case (reg_addr)
                ldo_dis_pkg::ldo_second_control_off: reg_rdata <= {2'h0, second_ctrl_reg};
                ldo_dis_pkg::ldo_third_control_off:  reg_rdata <= {2'h0, third_ctrl_reg};
                ldo_dis_pkg::buck_discharge_select_off: reg_rdata <= dis_sel_reg;
                default: reg_rdata <= 8'h00;
            endcase
        end else begin
            reg_rdata <= 8'h00;
        end
    end

    // ==========================================================
    // Regulator control
    function automatic logic sleep_pick(input logic [1:0] sel, input logic strap,
                                        input logic pa, input logic pb);
        logic pin;
        pin = strap ? pb : pa;
        // Reserved codes treated as disabled
        sleep_pick = (sel == ldo_dis_pkg::sleep_on_code) && !pin;
    endfunction : sleep_pick

    function automatic ldo_dis_pkg::discharge_s dis_decode(input logic [1:0] code,
                                                          input logic rail_on);
        ldo_dis_pkg::discharge_s d;
        d = '0;
        if (!rail_on) begin
            d.load_100_ohm = (code == ldo_dis_pkg::dis_100_ohm);
            d.load_200_ohm = (code == ldo_dis_pkg::dis_200_ohm);
            d.load_500_ohm = (code == ldo_dis_pkg::dis_500_ohm);
        end
        dis_decode = d;
    endfunction : dis_decode

    always_ff @(posedge mclk) begin
        if (reset) begin
            second_reg_enable         <= 1'b0;
            third_reg_enable          <= 1'b0;
            second_reg_use_sleep_code <= 1'b0;
            third_reg_use_sleep_code  <= 1'b0;
        end else begin
            second_reg_enable <= second_ctrl_reg.on_permit && second_req;
            third_reg_enable  <= third_ctrl_reg.on_permit && third_req;
            second_reg_use_sleep_code <= sleep_pick(second_ctrl_reg.sleep_sel,
                strap_second_reg, pin_a_s, pin_b_s);
            third_reg_use_sleep_code  <= sleep_pick(third_ctrl_reg.sleep_sel,
                strap_third_reg, pin_a_s, pin_b_s);
        end
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            for (int i = 0; i < 4; i++)
                buck_discharge[i] <= '0;
        end else begin
            for (int i = 0; i < 4; i++)
                buck_discharge[i] <= dis_decode(dis_sel_next[2*i +: 2],
                                                buck_en_s[i]);
        end
    end

    // ==========================================================
    // Checks
    chk_permit_forces_off: assert property (
        @(posedge mclk) disable iff (reset)
        !second_ctrl_reg.on_permit |=> !second_reg_enable)
        else $error("second regulator on without permit");

    chk_third_permit_off: assert property (
        @(posedge mclk) disable iff (reset)
        !third_ctrl_reg.on_permit |=> !third_reg_enable)
        else $error("third regulator on without permit");

    chk_permit_pin_on: assert property (
        @(posedge mclk) disable iff (reset)
        (second_ctrl_reg.on_permit && second_req)
        |=> second_reg_enable)
        else $error("second regulator off despite permit and request");

    chk_sleep_off_normal: assert property (
        @(posedge mclk) disable iff (reset)
        (second_ctrl_reg.sleep_sel == ldo_dis_pkg::sleep_off_code)
        |=> !second_reg_use_sleep_code)
        else $error("sleep code used while sleep disabled");

    chk_sleep_off_third: assert property (
        @(posedge mclk) disable iff (reset)
        (third_ctrl_reg.sleep_sel == ldo_dis_pkg::sleep_off_code)
        |=> !third_reg_use_sleep_code)
        else $error("third sleep code used while sleep disabled");

    chk_sleep_pin_low: assert property (
        @(posedge mclk) disable iff (reset)
        (third_ctrl_reg.sleep_sel == ldo_dis_pkg::sleep_on_code
            && !(strap_third_reg ? pin_b_s : pin_a_s))
        |=> third_reg_use_sleep_code)
        else $error("sleep code not used while pin low");

    chk_second_pin_low: assert property (
        @(posedge mclk) disable iff (reset)
        (second_ctrl_reg.sleep_sel == ldo_dis_pkg::sleep_on_code
            && !(strap_second_reg ? pin_b_s : pin_a_s))
        |=> second_reg_use_sleep_code)
        else $error("second sleep code not used while pin low");

    chk_sleep_pin_high: assert property (
        @(posedge mclk) disable iff (reset)
        (strap_second_reg ? pin_b_s : pin_a_s)
        |=> !second_reg_use_sleep_code)
        else $error("sleep code used while pin high");

    chk_third_pin_high: assert property (
        @(posedge mclk) disable iff (reset)
        (strap_third_reg ? pin_b_s : pin_a_s)
        |=> !third_reg_use_sleep_code)
        else $error("third sleep code used while pin high");

    chk_strap_held: assert property (
        @(posedge mclk) disable iff (reset)
        strap_taken_reg |=> $stable({strap_second_reg, strap_third_reg}))
        else $error("sleep pin choice changed after capture");

    chk_rise_clears_sel: assert property (
        @(posedge mclk) disable iff (reset)
        buck_rise[0] |=> dis_sel_reg[1:0] == ldo_dis_pkg::dis_none)
        else $error("discharge selector not cleared on enable");

    chk_rise_clears_top: assert property (
        @(posedge mclk) disable iff (reset)
        buck_rise[3] |=> dis_sel_reg[7:6] == ldo_dis_pkg::dis_none)
        else $error("fourth selector not cleared on enable");

    chk_discharge_off_on: assert property (
        @(posedge mclk) disable iff (reset)
        $past(buck_en_s[2]) |-> buck_discharge[2] == 3'h0)
        else $error("discharge applied on enabled rail");

    chk_enabled_rail_idle: assert property (
        @(posedge mclk) disable iff (reset)
        $past(buck_en_s[0]) |-> buck_discharge[0] == 3'h0)
        else $error("discharge applied on enabled first rail");

    chk_discharge_100: assert property (
        @(posedge mclk) disable iff (reset)
        (!buck_en_s[1] && dis_sel_next[3:2] == ldo_dis_pkg::dis_100_ohm)
        |=> buck_discharge[1].load_100_ohm)
        else $error("100 ohm not applied");

    chk_discharge_200: assert property (
        @(posedge mclk) disable iff (reset)
        (!buck_en_s[2] && dis_sel_next[5:4] == ldo_dis_pkg::dis_200_ohm)
        |=> buck_discharge[2].load_200_ohm)
        else $error("200 ohm not applied");

    chk_discharge_500: assert property (
        @(posedge mclk) disable iff (reset)
        (!buck_en_s[3] && dis_sel_next[7:6] == ldo_dis_pkg::dis_500_ohm)
        |=> buck_discharge[3].load_500_ohm)
        else $error("500 ohm not applied");

    chk_write_stores: assert property (
        @(posedge mclk) disable iff (reset)
        (reg_write && reg_addr == ldo_dis_pkg::buck_discharge_select_off
            && buck_rise == 4'h0)
        |=> dis_sel_reg == $past(reg_wdata))
        else $error("discharge write lost");

    chk_read_discharge: assert property (
        @(posedge mclk) disable iff (reset)
        (reg_read && reg_addr == ldo_dis_pkg::buck_discharge_select_off)
        |=> reg_rdata == $past(dis_sel_reg))
        else $error("discharge read data wrong");

    chk_reserved_zero: assert property (
        @(posedge mclk) disable iff (reset)
        (reg_read && reg_addr == ldo_dis_pkg::ldo_second_control_off)
        |=> reg_rdata[7:6] == 2'h0)
        else $error("reserved bits not zero");

    chk_reserved_third: assert property (
        @(posedge mclk) disable iff (reset)
        (reg_read && reg_addr == ldo_dis_pkg::ldo_third_control_off)
        |=> reg_rdata[7:6] == 2'h0)
        else $error("third reserved bits not zero");
endmodule : ldo_ctrl_discharge_regs
`default_nettype wire

// ===== ldo_ctrl_discharge_regs_bench.sv
// Self-checking bench for the regulator control and discharge registers
`timescale 1ns/1ps
`default_nettype none
module ldo_ctrl_discharge_regs_bench;
    logic                      mclk;
    logic                      reset;
    logic [7:0]                reg_addr;
    logic [7:0]                reg_wdata;
    logic                      reg_write;
    logic                      reg_read;
    logic [7:0]                reg_rdata;
    logic                      second_reg_pin_strap;
    logic                      third_reg_pin_strap;
    logic                      sleep_select_pin_a;
    logic                      sleep_select_pin_b;
    logic                      second_reg_enable_request;
    logic                      third_reg_enable_request;
    logic [3:0]                buck_rail_enabled;
    logic                      second_reg_enable;
    logic                      third_reg_enable;
    logic                      second_reg_use_sleep_code;
    logic                      third_reg_use_sleep_code;
    ldo_dis_pkg::discharge_s   buck_discharge [4];
    logic [7:0]                exp_q [$];
    logic                      rd_seen = 1'b0;
    int                        error_cnt;
    int                        n_compared;
    int                        i;
    int                        j;
    logic [7:0]                d;

    ldo_ctrl_discharge_regs u_dut (.mclk, .reset, .reg_addr, .reg_wdata, .reg_write,
        .reg_read, .reg_rdata, .second_reg_pin_strap, .third_reg_pin_strap,
        .sleep_select_pin_a, .sleep_select_pin_b, .second_reg_enable_request,
        .third_reg_enable_request, .buck_rail_enabled, .second_reg_enable,
        .third_reg_enable, .second_reg_use_sleep_code, .third_reg_use_sleep_code,
        .buck_discharge);

    // ==========================================================
    // Clock and helpers
    initial begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end

    function automatic ldo_dis_pkg::discharge_s dec(input logic [1:0] c);
        return {c == 2'h1, c == 2'h2, c == 2'h3};
    endfunction : dec

    task automatic fail(input string msg);
        error_cnt++;
        $display("[ERR] %0t %s", $time, msg);
    endtask : fail

    task automatic cmp_byte(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp) fail($sformatf("read %h expected %h", got, exp));
    endtask : cmp_byte

    task automatic cmp_bit(input logic got, input logic exp, input string what);
        n_compared++;
        if (got !== exp) fail($sformatf("%s is %b expected %b", what, got, exp));
    endtask : cmp_bit

    task automatic cmp_dis(input ldo_dis_pkg::discharge_s got, input int k,
                           input ldo_dis_pkg::discharge_s exp);
        n_compared++;
        if (got !== exp) fail($sformatf("discharge %0d is %b expected %b", k, got, exp));
    endtask : cmp_dis

    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge mclk);
        reg_addr  <= a;
        reg_wdata <= v;
        reg_write <= 1'b1;
        @(posedge mclk);
        reg_write <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [7:0] v);
        exp_q.push_back(v);
        @(posedge mclk);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge mclk);
        reg_read <= 1'b0;
    endtask : rd

    // Pins pass two sync stages, so five edges is ample
    task automatic settle();
        repeat (5) @(posedge mclk);
        #1;
    endtask : settle

    task automatic close_out();
        if (exp_q.size() != 0) fail("reads left unchecked");
        $display("Counts: %0d compared, %0d errors", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : close_out

    // ==========================================================
    // Read data monitor: data stands only in the cycle after the strobe
    // Sampled mid-cycle, where the read data are settled
    always @(negedge mclk) begin
        if (rd_seen && exp_q.size() > 0) cmp_byte(reg_rdata, exp_q.pop_front());
        else if (rd_seen) fail("read data with no expectation");
        rd_seen <= reg_read;
    end

    initial begin
        #(20 * 3000);
        fail("watchdog expired");
        close_out();
    end

    // ==========================================================
    // Main sequence
    initial begin
        {reset, reg_write, reg_read} = 3'h4;
        {reg_addr, reg_wdata} = 16'h0000;
        {sleep_select_pin_a, sleep_select_pin_b} = 2'h0;
        {second_reg_enable_request, third_reg_enable_request} = 2'h0;
        buck_rail_enabled = 4'h0;
        second_reg_pin_strap = 1'b0;
        third_reg_pin_strap = 1'b1;
        error_cnt = 0;
        n_compared = 0;
        void'($urandom(32'hA1DAC952));
        repeat (2) @(posedge mclk);
        reset <= 1'b0;
        rd(ldo_dis_pkg::ldo_second_control_off, ldo_dis_pkg::ldo_ctrl_reset);
        rd(ldo_dis_pkg::ldo_third_control_off, ldo_dis_pkg::ldo_ctrl_reset);
        rd(ldo_dis_pkg::buck_discharge_select_off, ldo_dis_pkg::dis_sel_reset);
        rd(8'h41, 8'h00);
        wr(8'h28, 8'hFD);
        rd(8'h28, 8'h3D);
        wr(8'h29, 8'hCD);
        rd(8'h29, 8'h0D);
        for (i = 0; i < 10; i++) begin
            d = (i == 0) ? 8'h1B : (i == 1) ? 8'hE4 : 8'($urandom);
            wr(8'h40, d);
            rd(8'h40, d);
            settle();
            for (j = 0; j < 4; j++) cmp_dis(buck_discharge[j], j, dec(d[2*j+:2]));
        end
        // Sleep field 11 then 00, every pin combination
        for (j = 0; j < 2; j++) begin
            wr(8'h28, j ? 8'h0D : 8'h3D);
            wr(8'h29, j ? 8'h0D : 8'h3D);
            for (i = 0; i < 4; i++) begin
                @(posedge mclk);
                sleep_select_pin_a <= i[0];
                sleep_select_pin_b <= i[1];
                settle();
                cmp_bit(second_reg_use_sleep_code, !j && !i[0], "sleep2");
                cmp_bit(third_reg_use_sleep_code, !j && !i[1], "sleep3");
            end
        end
        @(posedge mclk);
        second_reg_enable_request <= 1'b1;
        third_reg_enable_request <= 1'b1;
        settle();
        cmp_bit(second_reg_enable, 1'b1, "en2");
        wr(8'h28, 8'h0C);
        settle();
        cmp_bit(second_reg_enable, 1'b0, "en2");
        cmp_bit(third_reg_enable, 1'b1, "en3");
        @(posedge mclk);
        third_reg_enable_request <= 1'b0;
        settle();
        cmp_bit(third_reg_enable, 1'b0, "en3");
        // Enabling a rail clears its selector and blocks its load
        wr(8'h40, 8'hFF);
        buck_rail_enabled <= 4'h2;
        settle();
        rd(8'h40, 8'hF3);
        cmp_dis(buck_discharge[1], 1, dec(2'h0));
        cmp_dis(buck_discharge[0], 0, dec(2'h3));
        buck_rail_enabled <= 4'hF;
        settle();
        rd(8'h40, 8'h00);
        wr(8'h40, 8'hAA);
        settle();
        for (j = 0; j < 4; j++) cmp_dis(buck_discharge[j], j, dec(2'h0));
        @(posedge mclk);
        buck_rail_enabled <= 4'h0;
        settle();
        for (j = 0; j < 4; j++) cmp_dis(buck_discharge[j], j, dec(2'h2));
        repeat (4) @(posedge mclk);
        close_out();
    end
endmodule : ldo_ctrl_discharge_regs_bench
`default_nettype wire
